// ==== logic/sopi_pkg.sv ====
// Constants, field layout and carrier types of the safe output parameter image
package sopi_pkg;

  // ==========================================================================
  // Image layout
  localparam logic [3:0] IDX_SUPPLY = 4'h0;
  localparam logic [3:0] IDX_IO_FB = 4'h1;
  localparam logic [3:0] IDX_Z1_FB = 4'h2;
  localparam logic [3:0] IDX_Z23_FB = 4'h3;
  localparam logic [3:0] IDX_CONN0 = 4'h4;
  localparam logic [3:0] IDX_CONN2 = 4'h6;
  localparam logic [3:0] CHAN_IMG_LEN = 4'h5;
  localparam logic [3:0] MOD_IMG_LEN = 4'hc;
  localparam logic [3:0] MOD_USER_LEN = 4'h8;

  // ==========================================================================
  // Field positions
  localparam int SUP_IO_BIT = 0;
  localparam int SUP_Z1_BIT = 1;
  localparam int SUP_Z3_BIT = 3;
  localparam logic [7:0] SUPPLY_MASK = 8'h0f;
  localparam int OFF_LSB = 0;
  localparam int ON_LSB = 3;
  localparam int FB_EN_BIT = 6;
  localparam int FB_EN_Z3_BIT = 7;
  localparam int CODE_W = 3;

  // ==========================================================================
  // Delay codes and their times
  localparam logic [2:0] CODE_5S = 3'h3;
  localparam logic [2:0] CODE_1S = 3'h4;
  localparam logic [2:0] CODE_500MS = 3'h5;
  localparam logic [2:0] CODE_200MS = 3'h6;
  localparam logic [2:0] CODE_100MS = 3'h7;
  localparam logic [15:0] DLY_5S_MS = 16'h1388;
  localparam logic [15:0] DLY_1S_MS = 16'h03e8;
  localparam logic [15:0] DLY_500MS_MS = 16'h01f4;
  localparam logic [15:0] DLY_200MS_MS = 16'h00c8;
  localparam logic [15:0] DLY_100MS_MS = 16'h0064;
  localparam logic [15:0] DLY_NONE_MS = 16'h0000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic fb_en;
    logic [15:0] on_ms;
    logic [15:0] off_ms;
  } sopi_zone_t;

  // Zone order: 0 = I/O modules, 1..3 = valve zones
  typedef sopi_zone_t [3:0] sopi_zone_arr_t;
  typedef logic [3:0][7:0] sopi_conn_arr_t;

  typedef struct packed {
    logic [7:0][7:0] shadow;
    logic [3:0] supply;
    logic [2:0] pilot;
    sopi_zone_arr_t zone;
    sopi_conn_arr_t conn;
    logic param_ok;
    logic reject;
  } sopi_state_t;

endpackage

// ==== logic/sopi_image.sv ====
// Decoder of the cyclic safe output process image: supply switches and parameters
//
// Summary of operation
// - Channel mode image is five bytes long
// - Byte 0 bits 0-3 switch supplies
// - Zone supply also feeds first pilot valve
// - Channel mode bytes 1-4 carry no data
// - Module mode image twelve bytes, eight usable
// - Zero parameter byte disables that function
// - Module mode bytes 8-11 are protocol only
// - OFF delay code decodes 5 s to 100 ms
// - ON delay code uses same encoding
// - Byte 1 bit 6 enables I/O feedback
// - Byte 2 configures valve zone 1 alike
// - Byte 3 shared delays, enables zones 2, 3
// - Bytes 4-7 configure one input connector each
// - Status high only for valid parameter image
`timescale 1ns/1ps

module sopi_image (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mode_module,
  input wire logic word_variant,
  input wire logic img_wr,
  input wire logic [3:0] img_idx,
  input wire logic [7:0] img_byte,
  input wire logic img_word_wr,
  input wire logic [3:0] img_word_idx,
  input wire logic [15:0] img_word,
  input wire logic img_commit,
  output logic [3:0] actuator_supply_en,
  output logic [2:0] pilot_supply_en,
  output sopi_pkg::sopi_zone_arr_t zone_cfg,
  output sopi_pkg::sopi_conn_arr_t conn_param,
  output logic param_ok,
  output logic img_reject
);
  import sopi_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] delay_ms(input logic [2:0] code);
    case (code)
      CODE_5S: delay_ms = DLY_5S_MS;
      CODE_1S: delay_ms = DLY_1S_MS;
      CODE_500MS: delay_ms = DLY_500MS_MS;
      CODE_200MS: delay_ms = DLY_200MS_MS;
      CODE_100MS: delay_ms = DLY_100MS_MS;
      default: delay_ms = DLY_NONE_MS;
    endcase
  endfunction

  // Both delay fields of a byte must carry a defined code
  function automatic logic codes_ok(input logic [7:0] b);
    codes_ok = (b[OFF_LSB +: CODE_W] >= CODE_5S) && (b[ON_LSB +: CODE_W] >= CODE_5S);
  endfunction

  function automatic sopi_zone_t zone_of(input logic [7:0] b, input logic en);
    zone_of.fb_en = en;
    zone_of.on_ms = delay_ms(b[ON_LSB +: CODE_W]);
    zone_of.off_ms = delay_ms(b[OFF_LSB +: CODE_W]);
  endfunction

  // ==========================================================================
  // State
  sopi_state_t st_r;
  sopi_state_t st_nxt;
  logic [7:0][7:0] ws;
  logic byte_ok;
  logic word_ok;
  logic img_valid;
  logic fb_io;
  logic fb_z1;
  logic fb_z2;
  logic fb_z3;

  always_comb begin
    st_nxt = st_r;
    ws = st_r.shadow;
    // Channel mode accepts byte 0 only; module mode only the user bytes
    if (!mode_module) begin
      byte_ok = (img_idx < CHAN_IMG_LEN) && (img_idx == IDX_SUPPLY);
    end else if (word_variant && (img_idx >= IDX_CONN0)) begin
      byte_ok = 1'b0;
    end else begin
      byte_ok = (img_idx < MOD_USER_LEN);
    end
    word_ok = mode_module && word_variant &&
              ((img_word_idx == IDX_CONN0) || (img_word_idx == IDX_CONN2));
    if (img_wr && byte_ok) begin
      ws[img_idx[2:0]] = img_byte;
    end
    if (img_word_wr && word_ok) begin
      // High byte lands in the lower byte index, as on the wire
      ws[img_word_idx[2:0]] = img_word[15:8];
      ws[img_word_idx[2:0] + 3'h1] = img_word[7:0];
    end
    ws[IDX_SUPPLY] = ws[IDX_SUPPLY] & SUPPLY_MASK;
    st_nxt.shadow = ws;
    st_nxt.reject = (img_wr && !byte_ok) || (img_word_wr && !word_ok);

    fb_io = ws[IDX_IO_FB][FB_EN_BIT];
    fb_z1 = ws[IDX_Z1_FB][FB_EN_BIT];
    fb_z2 = ws[IDX_Z23_FB][FB_EN_BIT];
    fb_z3 = ws[IDX_Z23_FB][FB_EN_Z3_BIT];
    // An all-zero parameter set is not a valid image
    img_valid = (ws[7:1] != '0) &&
                (!fb_io || codes_ok(ws[IDX_IO_FB])) &&
                (!fb_z1 || codes_ok(ws[IDX_Z1_FB])) &&
                (!(fb_z2 || fb_z3) || codes_ok(ws[IDX_Z23_FB]));

    if (img_commit) begin
      if (!mode_module) begin
        st_nxt.supply = ws[IDX_SUPPLY][3:0];
        st_nxt.param_ok = 1'b0;
        st_nxt.zone = '0;
        st_nxt.conn = '0;
      end else if (img_valid) begin
        st_nxt.supply = ws[IDX_SUPPLY][3:0];
        st_nxt.param_ok = 1'b1;
        // A zero byte leaves its enable bits clear, which disables it
        st_nxt.zone[0] = zone_of(ws[IDX_IO_FB], fb_io);
        st_nxt.zone[1] = zone_of(ws[IDX_Z1_FB], fb_z1);
        st_nxt.zone[2] = zone_of(ws[IDX_Z23_FB], fb_z2);
        st_nxt.zone[3] = zone_of(ws[IDX_Z23_FB], fb_z3);
        st_nxt.conn = ws[7:4];
      end else begin
        // Safe side: a bad parameter image drops every supply
        st_nxt.supply = '0;
        st_nxt.param_ok = 1'b0;
        st_nxt.zone = '0;
        st_nxt.conn = '0;
      end
    end
    st_nxt.pilot = st_nxt.supply[SUP_Z3_BIT:SUP_Z1_BIT];
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign actuator_supply_en = st_r.supply;
  assign pilot_supply_en = st_r.pilot;
  assign zone_cfg = st_r.zone;
  assign conn_param = st_r.conn;
  assign param_ok = st_r.param_ok;
  assign img_reject = st_r.reject;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Properties on ws see the image as the commit applies it, same-cycle writes included
  pilot_follow_a: assert property (
    pilot_supply_en == actuator_supply_en[SUP_Z3_BIT:SUP_Z1_BIT])
    else $error("pilot supply differs from zone supply");

  chan_len_a: assert property (
    !mode_module && img_wr && (img_idx != IDX_SUPPLY) |=> img_reject)
    else $error("channel mode took a byte other than byte 0");

  chan_cont_a: assert property (
    !mode_module && img_wr && (img_idx >= IDX_IO_FB) && (img_idx < CHAN_IMG_LEN)
    |=> $stable(st_r.shadow[7:1]))
    else $error("container byte reached the image");

  mod_len_a: assert property (
    mode_module && img_wr && (img_idx >= MOD_USER_LEN) && (img_idx < MOD_IMG_LEN)
    |=> img_reject)
    else $error("module mode took a protocol byte");

  mod_resv_a: assert property (
    mode_module && img_wr && !img_word_wr && (img_idx >= MOD_USER_LEN)
    |=> $stable(st_r.shadow))
    else $error("bytes 8 to 11 changed the image");

  chan_supply_a: assert property (
    !mode_module && img_commit && img_wr && (img_idx == IDX_SUPPLY)
    |=> actuator_supply_en == $past(img_byte[3:0]) && !param_ok)
    else $error("channel supply not taken from byte 0");

  word_pack_a: assert property (
    img_word_wr && word_ok && !img_wr
    |=> st_r.shadow[$past(img_word_idx[2:0])] == $past(img_word[15:8]))
    else $error("word high byte misplaced");

  byte_refuse_a: assert property (
    mode_module && word_variant && img_wr && (img_idx >= IDX_CONN0) |=> img_reject)
    else $error("byte write to word area not refused");

  zero_param_a: assert property (
    mode_module && img_commit && (ws[7:1] == '0) |=> !param_ok && actuator_supply_en == '0)
    else $error("all-zero parameters accepted");

  bad_code_a: assert property (
    mode_module && img_commit && fb_io && (ws[IDX_IO_FB][OFF_LSB +: CODE_W] < CODE_5S)
    |=> !param_ok && actuator_supply_en == '0)
    else $error("reserved delay code accepted");

  off_decode_a: assert property (
    mode_module && img_commit && img_valid
    |=> param_ok && zone_cfg[0].off_ms == delay_ms($past(ws[IDX_IO_FB][2:0])))
    else $error("OFF delay decoded wrongly");

  on_decode_a: assert property (
    mode_module && img_commit && img_valid
    |=> zone_cfg[1].on_ms == delay_ms($past(ws[IDX_Z1_FB][5:3])))
    else $error("ON delay decoded wrongly");

  disable_a: assert property (
    mode_module && img_commit && img_valid && (ws[IDX_Z1_FB] == '0)
    |=> !zone_cfg[1].fb_en)
    else $error("zero byte did not disable zone");

  shared_delay_a: assert property (
    zone_cfg[2].on_ms == zone_cfg[3].on_ms && zone_cfg[2].off_ms == zone_cfg[3].off_ms)
    else $error("zones 2 and 3 delays differ");

  conn_load_a: assert property (
    mode_module && img_commit && img_valid |=> conn_param == $past(ws[7:4]))
    else $error("connector parameters not loaded");

  io_enable_a: assert property (
    mode_module && img_commit && img_valid
    |=> zone_cfg[0].fb_en == $past(ws[IDX_IO_FB][FB_EN_BIT]))
    else $error("I/O feedback enable wrong");

  z1_enable_a: assert property (
    mode_module && img_commit && img_valid
    |=> zone_cfg[1].fb_en == $past(ws[IDX_Z1_FB][FB_EN_BIT]))
    else $error("zone 1 feedback enable wrong");

  status_chan_a: assert property (
    !mode_module && img_commit |=> !param_ok)
    else $error("status set in channel mode");

  z2_enable_a: assert property (
    mode_module && img_commit && img_valid
    |=> zone_cfg[2].fb_en == $past(ws[IDX_Z23_FB][FB_EN_BIT]))
    else $error("zone 2 feedback enable wrong");

  z3_enable_a: assert property (
    mode_module && img_commit && img_valid
    |=> zone_cfg[3].fb_en == $past(ws[IDX_Z23_FB][FB_EN_Z3_BIT]))
    else $error("zone 3 feedback enable wrong");

  z3_off_a: assert property (
    mode_module && img_commit && img_valid
    |=> zone_cfg[3].off_ms == delay_ms($past(ws[IDX_Z23_FB][OFF_LSB +: CODE_W])))
    else $error("zone 3 OFF delay wrong");

  word_low_a: assert property (
    img_word_wr && word_ok && !img_wr
    |=> st_r.shadow[$past(img_word_idx[2:0]) + 3'h1] == $past(img_word[7:0]))
    else $error("word low byte misplaced");

  word_refuse_a: assert property (
    img_word_wr && !word_ok |=> img_reject)
    else $error("word write outside word area not refused");

  supply_resv_a: assert property (
    (st_r.shadow[IDX_SUPPLY] & ~SUPPLY_MASK) == 8'h00)
    else $error("reserved supply bits stored");

  bad_clear_a: assert property (
    mode_module && img_commit && !img_valid
    |=> !param_ok && zone_cfg == '0 && conn_param == '0)
    else $error("invalid image left parameters applied");

  chan_clear_a: assert property (
    !mode_module && img_commit |=> zone_cfg == '0 && conn_param == '0)
    else $error("channel mode kept module parameters");

  mod_supply_a: assert property (
    mode_module && img_commit && img_valid
    |=> actuator_supply_en == $past(ws[IDX_SUPPLY][3:0]))
    else $error("module supply not taken from byte 0");

  status_hold_a: assert property (
    !img_commit
    |=> $stable(param_ok) && $stable(actuator_supply_en))
    else $error("status or supply moved without a commit");

  chan_commit_c: cover property (!mode_module && img_commit ##1 actuator_supply_en != '0);
  mod_ok_c: cover property (mode_module && img_commit && img_valid ##1 param_ok);
  mod_bad_c: cover property (param_ok ##1 img_commit ##1 !param_ok);
  word_wr_c: cover property (img_word_wr && word_ok ##1 !img_reject);
  chan_wrcommit_c: cover property (!mode_module && img_commit && img_wr);

endmodule

// ==== test/sopi_ctrl_model.sv ====
// Controller model that writes the safe output image byte-wise or word-wise
`timescale 1ns/1ps
module sopi_ctrl_model (
  input wire logic sys_clk,
  output logic mode_module,
  output logic word_variant,
  output logic img_wr,
  output logic [3:0] img_idx,
  output logic [7:0] img_byte,
  output logic img_word_wr,
  output logic [3:0] img_word_idx,
  output logic [15:0] img_word,
  output logic img_commit
);
  initial begin
    {mode_module, word_variant, img_wr, img_word_wr, img_commit} = '0;
    {img_idx, img_byte, img_word_idx, img_word} = '0;
  end
  task automatic mode(input logic m, input logic w);
    @(negedge sys_clk);
    mode_module = m;
    word_variant = w;
  endtask
  task automatic wb(input logic [3:0] i, input logic [7:0] d);
    @(negedge sys_clk);
    img_wr = 1'b1;
    img_idx = i;
    img_byte = d;
    @(negedge sys_clk);
    img_wr = 1'b0;
    // Released data must not keep its last value
    img_byte = ~d;
  endtask
  task automatic ww(input logic [3:0] i, input logic [15:0] d);
    @(negedge sys_clk);
    img_word_wr = 1'b1;
    img_word_idx = i;
    img_word = d;
    @(negedge sys_clk);
    img_word_wr = 1'b0;
    img_word = ~d;
  endtask
  // Write and commit in one cycle: the commit must see the new byte
  task automatic wbc(input logic [3:0] i, input logic [7:0] d);
    @(negedge sys_clk);
    img_wr = 1'b1;
    img_idx = i;
    img_byte = d;
    img_commit = 1'b1;
    @(negedge sys_clk);
    img_wr = 1'b0;
    img_commit = 1'b0;
    img_byte = ~d;
  endtask
  task automatic commit();
    @(negedge sys_clk);
    img_commit = 1'b1;
    @(negedge sys_clk);
    img_commit = 1'b0;
  endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench of the safe output image decoder
`timescale 1ns/1ps
module testbench;
  import sopi_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mode_module, word_variant, img_wr, img_word_wr, img_commit;
  logic [3:0] img_idx, img_word_idx, actuator_supply_en;
  logic [7:0] img_byte;
  logic [15:0] img_word;
  logic [2:0] pilot_supply_en;
  sopi_zone_arr_t zone_cfg;
  sopi_conn_arr_t conn_param;
  logic param_ok, img_reject;
  int failures = 0;
  int cmp_count = 0;
  always #25 sys_clk = ~sys_clk;
  sopi_image dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode_module(mode_module),
    .word_variant(word_variant), .img_wr(img_wr), .img_idx(img_idx), .img_byte(img_byte),
    .img_word_wr(img_word_wr), .img_word_idx(img_word_idx), .img_word(img_word),
    .img_commit(img_commit), .actuator_supply_en(actuator_supply_en),
    .pilot_supply_en(pilot_supply_en), .zone_cfg(zone_cfg), .conn_param(conn_param),
    .param_ok(param_ok), .img_reject(img_reject));
  sopi_ctrl_model ctl (.sys_clk(sys_clk), .mode_module(mode_module),
    .word_variant(word_variant), .img_wr(img_wr), .img_idx(img_idx), .img_byte(img_byte),
    .img_word_wr(img_word_wr), .img_word_idx(img_word_idx), .img_word(img_word),
    .img_commit(img_commit));
  // ==========================================================================
  // Helpers
  task automatic chk(input string n, input logic [131:0] s, input logic [131:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [15:0] ms(input logic [2:0] c);
    case (c)
      3'h3: return 16'h1388;
      3'h4: return 16'h03e8;
      3'h5: return 16'h01f4;
      3'h6: return 16'h00c8;
      3'h7: return 16'h0064;
      default: return 16'h0000;
    endcase
  endfunction
  function automatic sopi_zone_t zx(input logic [7:0] b, input logic en);
    return {en, ms(b[5:3]), ms(b[2:0])};
  endfunction
  task automatic load(input logic [7:0] b0, b1, b2, b3);
    ctl.wb(4'h0, b0);
    ctl.wb(4'h1, b1);
    ctl.wb(4'h2, b2);
    ctl.wb(4'h3, b3);
    ctl.commit();
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_chan();
    ctl.mode(1'b0, 1'b0);
    ctl.wb(4'h0, 8'hf5);
    ctl.commit();
    chk("supply", actuator_supply_en, 4'h5);
    chk("pilot", pilot_supply_en, 3'h2);
    chk("chan_ok", param_ok, 1'b0);
    chk("chan_zone", zone_cfg, '0);
    for (int i = 1; i < 5; i++) begin
      ctl.wb(4'(i), 8'h5b);
      chk("chan_reject", img_reject, 1'b1);
    end
    $display("t_chan done");
  endtask
  task automatic t_mod();
    logic [7:0] b;
    logic [7:0] b3;
    ctl.mode(1'b1, 1'b0);
    ctl.ww(4'h4, 16'h0000);
    chk("bit_word_reject", img_reject, 1'b1);
    for (int i = 4; i < 8; i++) begin
      ctl.wb(4'(i), 8'(8'h10 + i));
    end
    for (int c = 3; c < 8; c++) begin
      b = {2'b01, 3'(10 - c), 3'(c)};
      b3 = {2'b10, 3'(c), 3'(10 - c)};
      load(8'h0f, b, b | 8'h80, b3);
      chk("ok", param_ok, 1'b1);
      chk("supply", actuator_supply_en, 4'hf);
      chk("mod_pilot", pilot_supply_en, 3'h7);
      chk("zone_io", zone_cfg[0], zx(b, 1'b1));
      chk("zone1", zone_cfg[1], zx(b, 1'b1));
      chk("zone2", zone_cfg[2], zx(b3, 1'b0));
      chk("zone3", zone_cfg[3], zx(b3, 1'b1));
    end
    chk("conn", conn_param, {8'h17, 8'h16, 8'h15, 8'h14});
    $display("t_mod done");
  endtask
  task automatic t_bad();
    load(8'h0f, 8'h59, 8'h00, 8'h00);
    chk("bad_ok", param_ok, 1'b0);
    chk("bad_supply", actuator_supply_en, 4'h0);
    for (int i = 4; i < 8; i++) begin
      ctl.wb(4'(i), 8'h00);
    end
    load(8'h0f, 8'h00, 8'h00, 8'h00);
    chk("zero_ok", param_ok, 1'b0);
    load(8'h0f, 8'h01, 8'h00, 8'h00);
    chk("min_ok", param_ok, 1'b1);
    chk("min_zone", zone_cfg[0], '0);
    chk("min_conn", conn_param, '0);
    $display("t_bad done");
  endtask
  task automatic t_word();
    ctl.mode(1'b1, 1'b1);
    ctl.ww(4'h4, 16'ha1b2);
    chk("word_take", img_reject, 1'b0);
    ctl.ww(4'h6, 16'hc3d4);
    ctl.ww(4'h5, 16'h0000);
    chk("word_odd", img_reject, 1'b1);
    ctl.wb(4'h5, 8'h00);
    chk("word_byte", img_reject, 1'b1);
    ctl.wb(4'h8, 8'h00);
    chk("proto_byte", img_reject, 1'b1);
    load(8'h0f, 8'h5b, 8'h00, 8'h00);
    chk("word_conn", conn_param, {8'hd4, 8'hc3, 8'hb2, 8'ha1});
    chk("word_zone", zone_cfg[0], zx(8'h5b, 1'b1));
    ctl.mode(1'b0, 1'b0);
    ctl.wbc(4'h0, 8'ha9);
    chk("back_supply", actuator_supply_en, 4'h9);
    chk("back_pilot", pilot_supply_en, 3'h4);
    chk("back_ok", param_ok, 1'b0);
    chk("back_zone", zone_cfg, '0);
    chk("back_conn", conn_param, '0);
    $display("t_word done");
  endtask
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk("reset_ok", param_ok, 1'b0);
    t_chan();
    t_mod();
    t_bad();
    t_word();
    finish_test();
  end
  // Run needs about 140 cycles; this allows close to thirty times that
  initial begin
    #200000;
    failures++;
    finish_test();
  end
endmodule
